/* File: common/cwf_pkg.sv */
package cwf_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CWF_WIN_CFG0_OFF  = 8'h80;
  localparam logic [7:0] CWF_WIN_CFG1_OFF  = 8'h84;
  localparam logic [7:0] CWF_WIN_CFG2_OFF  = 8'h88;
  localparam logic [7:0] CWF_WIN_CFG3_OFF  = 8'h8c;
  localparam logic [7:0] CWF_CH_CFG_BASE   = 8'h00;
  localparam logic [7:0] CWF_IRQ_STAT_OFF  = 8'hc0;
  localparam logic [7:0] CWF_IRQ_CLR_OFF   = 8'hc4;
  localparam logic [7:0] CWF_IRQ_EN_OFF    = 8'hc8;
  localparam logic [7:0] CWF_STATE_OFF     = 8'hcc;

  localparam logic [31:0] CWF_REG_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int CWF_WMODE_BIT   = 16;
  localparam int CWF_WGATE_BIT   = 11;
  localparam int CWF_WSRC_LSB    = 8;
  localparam int CWF_WIRQ_LSB    = 0;
  localparam int CWF_FILTER_LENGTH_EXP_LSB    = 0;
  localparam int CWF_HYS_LSB     = 8;

  localparam int CWF_FILTER_LENGTH_EXP_W      = 3;
  localparam int CWF_HYS_W       = 7;
  localparam int CWF_CNT_W       = 8;
  localparam int CWF_PAIRS       = 4;
  localparam int CWF_CHANS       = 8;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CWF_EV_RISE    = 3'h0,
    CWF_EV_FALL    = 3'h1,
    CWF_EV_TOGGLE  = 3'h2,
    CWF_EV_INSIDE  = 3'h3,
    CWF_EV_OUTSIDE = 3'h4,
    CWF_EV_DONE    = 3'h5
  } cwf_evsrc_e;

  typedef enum logic [1:0] {
    CWF_IRQ_ENTER  = 2'h0,
    CWF_IRQ_LEAVE  = 2'h1,
    CWF_IRQ_TOGGLE = 2'h2,
    CWF_IRQ_DONE   = 2'h3
  } cwf_irqsel_e;

  typedef struct packed {
    logic        mode_on;
    logic        gate;
    logic [2:0]  src;
    logic [1:0]  irq_sel;
  } cwf_wcfg_s;

  typedef struct packed {
    logic [CWF_FILTER_LENGTH_EXP_W-1:0] filter_length_exp;
    logic [CWF_HYS_W-1:0]  filter_hysteresis;
  } cwf_ccfg_s;

endpackage

/* File: hw/cwf_filter.sv */
module cwf_filter (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic                          raw_i,
  input  wire logic                          ready_i,
  input  wire cwf_pkg::cwf_ccfg_s            cfg_i,
  output logic                               comp_o,
  output logic                               done_o
);
  import cwf_pkg::*;

  logic [CWF_CNT_W:0]   ones_counter_reg;
  logic [CWF_CNT_W:0]   sample_cnt_reg;
  logic [CWF_CNT_W:0]   block_size;
  logic [CWF_CNT_W:0]   half_size;
  logic [CWF_CNT_W+1:0] upper_thr;
  logic [CWF_CNT_W+1:0] lower_thr;
  logic [CWF_CNT_W:0]   ones_total;
  logic                 last_sample;

  assign block_size  = (CWF_CNT_W+1)'(1) << cfg_i.filter_length_exp;
  assign half_size   = block_size >> 1;
  assign upper_thr   = (CWF_CNT_W+2)'(half_size) + (CWF_CNT_W+2)'(cfg_i.filter_hysteresis); // [RULE_06]
  assign lower_thr   = ((CWF_CNT_W+2)'(half_size) > (CWF_CNT_W+2)'(cfg_i.filter_hysteresis)) ?
                       (CWF_CNT_W+2)'(half_size) - (CWF_CNT_W+2)'(cfg_i.filter_hysteresis) :
                       (CWF_CNT_W+2)'(0);
  assign last_sample = (sample_cnt_reg == block_size - (CWF_CNT_W+1)'(1));
  assign ones_total  = ones_counter_reg + (CWF_CNT_W+1)'(raw_i);

  // ---------------------------------------------------------------------------
  // Sampling and majority decision
  // ---------------------------------------------------------------------------
  // The raw input is already synchronised upstream, so no extra stage here.
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ones_counter_reg <= '0;
      sample_cnt_reg   <= '0;
      comp_o           <= 1'b0;
      done_o           <= 1'b0;
    end else if (cfg_i.filter_length_exp == '0) begin
      comp_o           <= raw_i; // [RULE_02]
      done_o           <= ready_i;
      ones_counter_reg <= '0;
      sample_cnt_reg   <= '0;
    end else begin
      done_o <= 1'b0;
      if (last_sample) begin
        sample_cnt_reg   <= '0;
        ones_counter_reg <= '0;
        done_o           <= 1'b1;
        if ((CWF_CNT_W+2)'(ones_total) >= upper_thr) begin
          comp_o <= 1'b1; // [RULE_03]
        end else if ((CWF_CNT_W+2)'(ones_total) < lower_thr) begin
          comp_o <= 1'b0; // [RULE_04]
        end
        // Between the thresholds the previous result is kept. [RULE_05]
      end else begin
        sample_cnt_reg   <= sample_cnt_reg + (CWF_CNT_W+1)'(1);
        ones_counter_reg <= ones_total; // [RULE_01]
      end
    end
  end

endmodule

/* File: hw/cwf_window.sv */
module cwf_window (
  input  wire logic                 core_clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 comp_lo_i,
  input  wire logic                 comp_hi_i,
  input  wire logic                 done_lo_i,
  input  wire logic                 done_hi_i,
  input  wire cwf_pkg::cwf_wcfg_s   cfg_i,
  output logic                      inside_o,
  output logic                      event_o,
  output logic                      irq_o
);
  import cwf_pkg::*;

  logic inside_reg;
  logic done_lo_reg;
  logic done_hi_reg;
  logic inside_now;
  logic rise;
  logic fall;
  logic both_done;
  logic ev_raw;
  logic irq_raw;

  // Inside the window: above the low threshold and below the high one.
  assign inside_now = comp_lo_i & ~comp_hi_i;
  assign rise       = inside_now & ~inside_reg;
  assign fall       = ~inside_now & inside_reg;
  assign both_done  = (done_lo_reg | done_lo_i) & (done_hi_reg | done_hi_i);

  always_comb begin
    case (cwf_evsrc_e'(cfg_i.src)) // [RULE_10]
      CWF_EV_RISE:    ev_raw = rise;
      CWF_EV_FALL:    ev_raw = fall;
      CWF_EV_TOGGLE:  ev_raw = rise | fall;
      CWF_EV_INSIDE:  ev_raw = both_done & inside_now; // [RULE_13]
      CWF_EV_OUTSIDE: ev_raw = both_done & ~inside_now;
      CWF_EV_DONE:    ev_raw = both_done;
      default:        ev_raw = 1'b0; // [RULE_14]
    endcase
  end

  always_comb begin
    case (cwf_irqsel_e'(cfg_i.irq_sel)) // [RULE_11]
      CWF_IRQ_ENTER:  irq_raw = rise;
      CWF_IRQ_LEAVE:  irq_raw = fall;
      CWF_IRQ_TOGGLE: irq_raw = rise | fall;
      CWF_IRQ_DONE:   irq_raw = both_done;
      default:        irq_raw = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      inside_reg  <= 1'b0;
      done_lo_reg <= 1'b0;
      done_hi_reg <= 1'b0;
      inside_o    <= 1'b0;
      event_o     <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      inside_reg  <= inside_now;
      inside_o    <= inside_now & cfg_i.mode_on;
      // A channel that finished early waits here for its partner.
      done_lo_reg <= both_done ? 1'b0 : (done_lo_reg | done_lo_i);
      done_hi_reg <= both_done ? 1'b0 : (done_hi_reg | done_hi_i);
      event_o     <= cfg_i.mode_on & cfg_i.gate & ev_raw; // [RULE_08] [RULE_09]
      irq_o       <= cfg_i.mode_on & irq_raw; // [RULE_08]
    end
  end

endmodule

/* File: hw/cwf_top.sv */
// Overview of operation
// [RULE_01] Count ones over two-power-length sample block.
// [RULE_02] Length exponent zero passes raw result.
// [RULE_03] Count at half plus hysteresis sets one.
// [RULE_04] Count below half minus hysteresis clears.
// [RULE_05] Between thresholds the result holds.
// [RULE_06] Hysteresis applies only with filter enabled.
// [RULE_07] Software keeps hysteresis below half block.
// [RULE_08] Bit 16 enables window mode per pair.
// [RULE_09] Gate bit allows or suppresses window events.
// [RULE_10] Three-bit source selects window event kind.
// [RULE_11] Two-bit select chooses window interrupt cause.
// [RULE_12] Channel events continue in window mode.
// [RULE_13] Events for inside, outside and pair done.
// [RULE_14] Reserved source encodings produce no event.
module cwf_top (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] comp_raw_i,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] comp_ready_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [31:0]                   reg_rdata_o,
  output logic      [cwf_pkg::CWF_CHANS-1:0] chan_out_o,
  output logic      [cwf_pkg::CWF_CHANS-1:0] chan_event_o,
  output logic      [cwf_pkg::CWF_PAIRS-1:0] win_out_o,
  output logic      [cwf_pkg::CWF_PAIRS-1:0] win_event_o,
  output logic                               irq_o
);
  import cwf_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------------
  logic [CWF_CHANS-1:0] raw_meta_reg;
  logic [CWF_CHANS-1:0] raw_sync_reg;
  logic [CWF_CHANS-1:0] rdy_meta_reg;
  logic [CWF_CHANS-1:0] rdy_sync_reg;

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      raw_meta_reg <= '0;
      raw_sync_reg <= '0;
      rdy_meta_reg <= '0;
      rdy_sync_reg <= '0;
    end else begin
      raw_meta_reg <= comp_raw_i;
      raw_sync_reg <= raw_meta_reg;
      rdy_meta_reg <= comp_ready_i;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [31:0]            win_cfg_reg [CWF_PAIRS];
  logic [31:0]            ch_cfg_reg  [CWF_CHANS];
  logic [CWF_PAIRS-1:0]   irq_stat_reg;
  logic [CWF_PAIRS-1:0]   irq_stat_next;
  logic [CWF_PAIRS-1:0]   irq_en_reg;

  function automatic cwf_wcfg_s win_fields(input logic [31:0] r);
    cwf_wcfg_s f;
    f.mode_on = r[CWF_WMODE_BIT];
    f.gate    = r[CWF_WGATE_BIT];
    f.src     = r[CWF_WSRC_LSB +: 3];
    f.irq_sel = r[CWF_WIRQ_LSB +: 2];
    return f;
  endfunction

  function automatic cwf_ccfg_s ch_fields(input logic [31:0] r);
    cwf_ccfg_s f;
    f.filter_length_exp = r[CWF_FILTER_LENGTH_EXP_LSB +: CWF_FILTER_LENGTH_EXP_W];
    f.filter_hysteresis  = r[CWF_HYS_LSB +: CWF_HYS_W];
    return f;
  endfunction

  function automatic logic [31:0] win_mask(input logic [31:0] d);
    logic [31:0] m;
    m = '0;
    m[CWF_WMODE_BIT]        = d[CWF_WMODE_BIT];
    m[CWF_WGATE_BIT]        = d[CWF_WGATE_BIT];
    m[CWF_WSRC_LSB +: 3]    = d[CWF_WSRC_LSB +: 3];
    m[CWF_WIRQ_LSB +: 2]    = d[CWF_WIRQ_LSB +: 2];
    return m;
  endfunction

  function automatic logic [31:0] ch_mask(input logic [31:0] d);
    logic [31:0] m;
    m = '0;
    m[CWF_FILTER_LENGTH_EXP_LSB +: CWF_FILTER_LENGTH_EXP_W] = d[CWF_FILTER_LENGTH_EXP_LSB +: CWF_FILTER_LENGTH_EXP_W];
    m[CWF_HYS_LSB +: CWF_HYS_W]   = d[CWF_HYS_LSB +: CWF_HYS_W];
    return m;
  endfunction

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < CWF_PAIRS; i++) begin
        win_cfg_reg[i] <= CWF_REG_RESET;
      end
      for (int i = 0; i < CWF_CHANS; i++) begin
        ch_cfg_reg[i] <= CWF_REG_RESET;
      end
      irq_en_reg <= '0;
    end else if (reg_wr_i) begin
      for (int i = 0; i < CWF_PAIRS; i++) begin
        if (reg_addr_i == CWF_WIN_CFG0_OFF + 8'(4 * i)) begin
          win_cfg_reg[i] <= win_mask(reg_wdata_i);
        end
      end
      for (int i = 0; i < CWF_CHANS; i++) begin
        if (reg_addr_i == CWF_CH_CFG_BASE + 8'(4 * i)) begin
          ch_cfg_reg[i] <= ch_mask(reg_wdata_i);
        end
      end
      if (reg_addr_i == CWF_IRQ_EN_OFF) begin
        irq_en_reg <= reg_wdata_i[CWF_PAIRS-1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Filters, one per channel
  // ---------------------------------------------------------------------------
  logic [CWF_CHANS-1:0] comp_f;
  logic [CWF_CHANS-1:0] done_f;
  logic [CWF_CHANS-1:0] comp_d_reg;

  for (genvar c = 0; c < CWF_CHANS; c++) begin : g_ch
    cwf_filter u_filter (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .raw_i      (raw_sync_reg[c]),
      .ready_i    (rdy_sync_reg[c]),
      .cfg_i      (ch_fields(ch_cfg_reg[c])),
      .comp_o     (comp_f[c]),
      .done_o     (done_f[c])
    );
  end

  // Channel outputs and toggle events run regardless of window mode. [RULE_12]
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      comp_d_reg   <= '0;
      chan_out_o   <= '0;
      chan_event_o <= '0;
    end else begin
      comp_d_reg   <= comp_f;
      chan_out_o   <= comp_f;
      chan_event_o <= comp_f ^ comp_d_reg; // [RULE_12]
    end
  end

  // ---------------------------------------------------------------------------
  // Window pairs
  // ---------------------------------------------------------------------------
  logic [CWF_PAIRS-1:0] win_inside;
  logic [CWF_PAIRS-1:0] win_ev;
  logic [CWF_PAIRS-1:0] win_irq;

  for (genvar p = 0; p < CWF_PAIRS; p++) begin : g_pair
    cwf_window u_window (
      .core_clk_i (core_clk_i),
      .reset_n_i  (reset_n_i),
      .comp_lo_i  (comp_f[2*p]),
      .comp_hi_i  (comp_f[2*p+1]),
      .done_lo_i  (done_f[2*p]),
      .done_hi_i  (done_f[2*p+1]),
      .cfg_i      (win_fields(win_cfg_reg[p])),
      .inside_o   (win_inside[p]),
      .event_o    (win_ev[p]),
      .irq_o      (win_irq[p])
    );
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      win_out_o   <= '0;
      win_event_o <= '0;
    end else begin
      win_out_o   <= win_inside;
      win_event_o <= win_ev; // [RULE_09]
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------------------
  // A new window interrupt in the clearing cycle stays set, so none is lost.
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (reg_wr_i && reg_addr_i == CWF_IRQ_CLR_OFF) begin
      irq_stat_next = irq_stat_next & ~reg_wdata_i[CWF_PAIRS-1:0];
    end
    irq_stat_next = irq_stat_next | win_irq; // [RULE_11]
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_stat_reg <= '0;
      irq_o        <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      irq_o        <= |(irq_stat_next & irq_en_reg);
    end
  end

  // ---------------------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < CWF_PAIRS; i++) begin
      if (reg_addr_i == CWF_WIN_CFG0_OFF + 8'(4 * i)) begin
        rd_mux = win_cfg_reg[i];
      end
    end
    for (int i = 0; i < CWF_CHANS; i++) begin
      if (reg_addr_i == CWF_CH_CFG_BASE + 8'(4 * i)) begin
        rd_mux = ch_cfg_reg[i];
      end
    end
    if (reg_addr_i == CWF_IRQ_STAT_OFF) begin
      rd_mux = 32'(irq_stat_reg);
    end
    if (reg_addr_i == CWF_IRQ_EN_OFF) begin
      rd_mux = 32'(irq_en_reg);
    end
    if (reg_addr_i == CWF_STATE_OFF) begin
      rd_mux = {8'h00, 4'h0, win_out_o, 8'h00, chan_out_o};
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule

/* File: verification/cwf_top_monitor.sv */
module cwf_top_monitor (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] comp_raw_i,
  input  wire logic [7:0]                    reg_addr_i,
  input  wire logic [31:0]                   reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [31:0]                   reg_rdata_o,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] chan_out_o,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] chan_event_o,
  input  wire logic [cwf_pkg::CWF_PAIRS-1:0] win_out_o,
  input  wire logic [cwf_pkg::CWF_PAIRS-1:0] win_event_o,
  input  wire logic                          irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwf_pkg::*;
  // ---------------------------------------------------------------------------
  // Shadow of pair 0 and channel 0 settings, rebuilt from the bus writes.
  // ---------------------------------------------------------------------------
  logic       mode_reg;
  logic       gate_reg;
  logic       rsvd_reg;
  logic       byp_reg;
  logic [3:0] en_reg;
  logic [2:0] age_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_reg <= 1'b0;
      gate_reg <= 1'b0;
      rsvd_reg <= 1'b0;
      byp_reg  <= 1'b1;
      en_reg   <= 4'h0;
      age_reg  <= 3'h0;
    end else begin
      // Past samples of the raw input are trusted only once they postdate reset.
      if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
      if (reg_wr_i && reg_addr_i == CWF_WIN_CFG0_OFF) begin
        mode_reg <= reg_wdata_i[CWF_WMODE_BIT];
        gate_reg <= reg_wdata_i[CWF_WGATE_BIT];
        rsvd_reg <= reg_wdata_i[CWF_WSRC_LSB+1 +: 2] == 2'h3;
      end
      if (reg_wr_i && reg_addr_i == CWF_CH_CFG_BASE) begin
        byp_reg <= reg_wdata_i[CWF_FILTER_LENGTH_EXP_LSB +: CWF_FILTER_LENGTH_EXP_W] == '0;
      end
      if (reg_wr_i && reg_addr_i == CWF_IRQ_EN_OFF) en_reg <= reg_wdata_i[3:0];
    end
  end
  // ---------------------------------------------------------------------------
  // Properties.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside the read answer cycle");
  AST_RD_UNMAPPED: assert property (reg_rd_i && reg_addr_i == 8'hf0 |=> reg_rdata_o == '0)
    else $error("unmapped read returned nonzero data");
  AST_CHAN_EVT: assert property (chan_event_o == (chan_out_o ^ $past(chan_out_o)))
    else $error("channel event does not match result toggle");
  AST_BYPASS: assert property ((age_reg == 3'h7 && byp_reg) [*6]
    |-> chan_out_o[0] == $past(comp_raw_i[0], 4))
    else $error("bypassed channel does not follow raw input");
  AST_MODE_OUT: assert property (!mode_reg [*4] |-> !win_out_o[0])
    else $error("window output high with window mode off");
  AST_MODE_EVT: assert property (!mode_reg [*4] |-> !win_event_o[0])
    else $error("window event with window mode off");
  AST_GATE: assert property ($fell(gate_reg) ##3 !gate_reg |-> !win_event_o[0])
    else $error("window event while the gate is closed");
  AST_RSVD: assert property (rsvd_reg [*4] |-> !win_event_o[0])
    else $error("window event on reserved source");
  AST_IRQ_MASK: assert property ((en_reg == 4'h0) [*3] |-> !irq_o)
    else $error("interrupt high with all enables off");
  cover property (win_event_o[0] && gate_reg);
  cover property (irq_o);
  cover property (chan_event_o[0] && mode_reg);
endmodule

bind cwf_top cwf_top_monitor u_mon (.core_clk_i, .reset_n_i, .comp_raw_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .chan_out_o, .chan_event_o,
  .win_out_o, .win_event_o, .irq_o);

/* File: verification/cwf_comp_model.sv */
module cwf_comp_model (
  input  wire logic                          core_clk_i,
  input  wire logic                          reset_n_i,
  input  wire logic [7:0]                    period_i,
  input  wire logic [7:0]                    ones_i,
  input  wire logic [cwf_pkg::CWF_CHANS-1:0] mask_i,
  input  wire logic                          ready_req_i,
  output logic      [cwf_pkg::CWF_CHANS-1:0] comp_raw_o,
  output logic      [cwf_pkg::CWF_CHANS-1:0] comp_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import cwf_pkg::*;
  // ---------------------------------------------------------------------------
  // Comparator outputs.
  // ---------------------------------------------------------------------------
  // A pattern whose period equals the sample block gives the same ones count
  // in every block, so the result does not depend on the block's phase.
  logic [7:0] phase_reg;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_reg    <= 8'h00;
      comp_raw_o   <= '0;
      comp_ready_o <= '0;
    end else begin
      phase_reg    <= (phase_reg + 8'h01 >= period_i) ? 8'h00 : phase_reg + 8'h01;
      comp_raw_o   <= (phase_reg < ones_i) ? mask_i : '0;
      comp_ready_o <= {CWF_CHANS{ready_req_i}};
    end
  end
endmodule

/* File: verification/cwf_top_test.sv */
module cwf_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cwf_pkg::*;
  logic                 core_clk_i  = 1'b0;
  logic                 reset_n_i;
  logic [7:0]           reg_addr_i  = 8'h00;
  logic [31:0]          reg_wdata_i = 32'h0000_0000;
  logic                 reg_wr_i    = 1'b0;
  logic                 reg_rd_i    = 1'b0;
  logic [7:0]           period      = 8'h01;
  logic [7:0]           ones        = 8'h00;
  logic [CWF_CHANS-1:0] mask        = '0;
  logic                 ready_req   = 1'b0;
  logic [CWF_CHANS-1:0] raw, rdy, chan_out, chan_event;
  logic [CWF_PAIRS-1:0] win_out, win_event;
  logic [31:0]          rdata;
  logic                 irq;
  int fails = 0, compares = 0, cycles = 0, n_win = 0, n_chan = 0, seed = 84;
  int ev_tab[8] = '{1, 1, 2, 1, 1, 2, 0, 0};

  cwf_comp_model u_comp (.core_clk_i, .reset_n_i, .period_i(period), .ones_i(ones),
    .mask_i(mask), .ready_req_i(ready_req), .comp_raw_o(raw), .comp_ready_o(rdy));
  cwf_top dut (.core_clk_i, .reset_n_i, .comp_raw_i(raw), .comp_ready_i(rdy), .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(rdata), .chan_out_o(chan_out),
    .chan_event_o(chan_event), .win_out_o(win_out), .win_event_o(win_event), .irq_o(irq));

  // ---------------------------------------------------------------------------
  // Clock, hang guard and event counters.
  // ---------------------------------------------------------------------------
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    n_win  += int'(win_event[0] === 1'b1);
    n_chan += int'(chan_event[0] === 1'b1);
    if (cycles == 10000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks.
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("Mismatches %0d, comparisons %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic drive(input int p, input int k, input logic [CWF_CHANS-1:0] m);
    @(posedge core_clk_i);
    period <= 8'(p);
    ones   <= 8'(k);
    mask   <= m;
  endtask
  task automatic pulse();
    @(posedge core_clk_i);
    ready_req <= 1'b1;
    @(posedge core_clk_i);
    ready_req <= 1'b0;
    tick(6);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------------
  initial begin
    int n, filter_hysteresis, k, prev, m, g, src, sel, x, q[$];
    logic [31:0] v;
    reset_n_i = 1'b0;
    tick(8);
    reset_n_i <= 1'b1;
    for (int p = 0; p < CWF_PAIRS; p++) begin
      rd(CWF_WIN_CFG0_OFF + 8'(4 * p), CWF_REG_RESET);
      v = $random(seed);
      wr(CWF_WIN_CFG0_OFF + 8'(4 * p), v);
      rd(CWF_WIN_CFG0_OFF + 8'(4 * p), v & 32'h0001_0f03);
      wr(CWF_WIN_CFG0_OFF + 8'(4 * p), CWF_REG_RESET);
    end
    rd(8'hf0, 32'h0000_0000);
    prev = 0;
    for (int f = 0; f < 4; f++) begin
      n = 1 << f;
      filter_hysteresis = 5;
      // Software keeps the hysteresis below half the block once filtering is on.
      if (f > 1) filter_hysteresis = ($random(seed) & 32'h0000_00ff) % (n / 2);
      if (f == 1) filter_hysteresis = 0;
      for (int c = 0; c < CWF_CHANS; c++) wr(8'(4 * c), 32'(f) | (32'(filter_hysteresis) << CWF_HYS_LSB));
      q = '{n, n / 2, n / 2 - filter_hysteresis, 0, n / 2 + filter_hysteresis - 1, n / 2 + filter_hysteresis};
      foreach (q[i]) begin
        k = (q[i] < 0) ? 0 : ((q[i] > n) ? n : q[i]);
        drive(n, k, '1);
        tick(3 * n + 8);
        if (f == 0) prev = int'(k > 0);
        else if (k >= n / 2 + filter_hysteresis) prev = 1;
        else if (k < n / 2 - filter_hysteresis) prev = 0;
        chk(32'(chan_out), prev ? 32'h0000_00ff : 32'h0000_0000);
      end
    end
    for (int c = 0; c < CWF_CHANS; c++) wr(8'(4 * c), CWF_REG_RESET);
    wr(CWF_IRQ_EN_OFF, 32'h0000_0001);
    for (int it = 0; it < 17; it++) begin
      m = int'(it > 0);
      x = (it == 0) ? 10 : it - 1;
      g = x / 8;
      src = x % 8;
      sel = it % 4;
      drive(1, 1, 8'h00);
      wr(CWF_WIN_CFG0_OFF, (32'(m) << CWF_WMODE_BIT) | (32'(g) << CWF_WGATE_BIT) |
        (32'(src) << CWF_WSRC_LSB) | 32'(sel));
      tick(8);
      wr(CWF_IRQ_CLR_OFF, 32'h0000_000f);
      #1;
      n_win = 0;
      n_chan = 0;
      pulse();
      drive(1, 1, 8'h01);
      tick(8);
      chk(32'(win_out), 32'(m));
      rd(CWF_STATE_OFF, (32'(m) << 16) | 32'h0000_0001);
      chk(32'(irq), 32'(m == 1 && sel != 1));
      rd(CWF_IRQ_STAT_OFF, 32'(m == 1 && sel != 1));
      pulse();
      drive(1, 1, 8'h00);
      tick(8);
      rd(CWF_IRQ_STAT_OFF, 32'(m));
      chk(32'(n_win), 32'((m == 1 && g == 1) ? ev_tab[src] : 0));
      chk(32'(n_chan), 32'h0000_0002);
    end
    wr(CWF_IRQ_EN_OFF, 32'h0000_0000);
    tick(3);
    chk(32'(irq), 32'h0000_0000);
    rd(CWF_IRQ_STAT_OFF, 32'h0000_0001);
    wr(CWF_IRQ_CLR_OFF, 32'h0000_0001);
    rd(CWF_IRQ_STAT_OFF, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
